// file: core/brctl_pkg.sv
// Package: register layout, field positions and timing counts of the bridge control block
package brctl_pkg;

    localparam logic [7:0] BRCTL_OFFSET = 8'h3c;
    localparam logic [31:0] BRCTL_RESET = 32'h0000_00ff;

    localparam int ERRMSG_EN_BIT = 27;
    localparam int DISCARD_STAT_BIT = 26;
    localparam int SEC_LEN_SEL_BIT = 25;
    localparam int PRI_LEN_SEL_BIT = 24;
    localparam int FAST_B2B_BIT = 23;
    localparam int SEC_RESET_BIT = 22;
    localparam int MA_MODE_BIT = 21;
    localparam int VIDEO_WIDE_BIT = 20;
    localparam int VIDEO_EN_BIT = 19;
    localparam int ALIAS_BLOCK_BIT = 18;
    localparam int SERR_FWD_BIT = 17;
    localparam int PARITY_RESP_BIT = 16;

    localparam logic [7:0] INT_PIN_VALUE = 8'h00;
    localparam logic [7:0] INT_LINE_VALUE = 8'hff;

    // Discard timer lengths as powers of two of secondary-bus clocks
    localparam int DISCARD_LONG_LOG2 = 15;
    localparam int DISCARD_SHORT_LOG2 = 10;

    localparam logic [31:0] VIDEO_MEM_LO = 32'h000a_0000;
    localparam logic [31:0] VIDEO_MEM_HI = 32'h000b_ffff;
    localparam logic [9:0] VIDEO_IO_A_LO = 10'h3b0;
    localparam logic [9:0] VIDEO_IO_A_HI = 10'h3bb;
    localparam logic [9:0] VIDEO_IO_B_LO = 10'h3c0;
    localparam logic [9:0] VIDEO_IO_B_HI = 10'h3df;
    // Bits 9:8 nonzero marks the top 768 bytes of a 1 KB block
    localparam logic [1:0] ISA_LOW_QUARTER = 2'b00;

    localparam logic [31:0] ALL_ONES = 32'hffff_ffff;

    typedef struct packed {
        logic errmsg_en;
        logic sec_len_sel;
        logic sec_reset;
        logic ma_mode;
        logic video_wide;
        logic video_en;
        logic alias_block;
        logic serr_fwd;
        logic parity_resp;
    } ctl_t;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic upstream;
        logic in_window;
        logic [31:0] addr;
    } access_t;

    typedef struct packed {
        logic fwd_down;
        logic fwd_up;
    } route_t;

endpackage : brctl_pkg

// file: core/discard_timer.sv
// Secondary discard timer for one delayed completion waiting at the queue head
`timescale 1ns/1ps
module discard_timer
    import brctl_pkg::*;
#(
    parameter int LONG_LOG2 = DISCARD_LONG_LOG2,
    parameter int SHORT_LOG2 = DISCARD_SHORT_LOG2
) (
    input wire logic clock,               // Bridge clock
    input wire logic sys_rst,             // Synchronous reset, high
    input wire logic clear,               // Secondary reset in force
    input wire logic short_sel,           // 1 selects short length
    input wire logic head_ready,          // Completion at head of queue
    input wire logic retried,             // Master repeated request
    output logic expired                  // One-cycle expiry pulse
);

    initial begin
        if (SHORT_LOG2 < 1 || SHORT_LOG2 > LONG_LOG2 || LONG_LOG2 > 30) begin
            $error("discard_timer: bad length parameters");
        end
    end

    logic [LONG_LOG2:0] count_r, count_nxt;
    logic running_r, running_nxt;
    logic expired_nxt;
    logic [LONG_LOG2:0] limit;

    assign limit = short_sel ? (LONG_LOG2+1)'(1 << SHORT_LOG2) : (LONG_LOG2+1)'(1 << LONG_LOG2);

    always_comb begin
        count_nxt = count_r;
        running_nxt = running_r;
        expired_nxt = 1'b0;
        if (clear || retried || !head_ready) begin
            count_nxt = '0;
            running_nxt = 1'b0;
        end else begin
            running_nxt = 1'b1;
            count_nxt = count_r + 1'b1;
            if (running_r && count_nxt >= limit) begin
                expired_nxt = 1'b1;
                running_nxt = 1'b0;
                count_nxt = '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_r <= '0;
            running_r <= 1'b0;
            expired <= 1'b0;
        end else begin
            count_r <= count_nxt;
            running_r <= running_nxt;
            expired <= expired_nxt;
        end
    end

endmodule : discard_timer

// file: core/address_router.sv
// Legacy video and alias-block routing qualifiers for one access
`timescale 1ns/1ps
module address_router
    import brctl_pkg::*;
(
    input ctl_t ctl,                      // Control fields
    input wire logic io_space_en,         // Command I/O space enable
    input wire logic mem_space_en,        // Command memory space enable
    input access_t acc,                   // Access under decode
    output route_t route                  // Routing decision
);

    function automatic logic video_io_hit(input logic [31:0] a, input logic wide);
        logic low_ok;
        low_ok = (a[9:0] >= VIDEO_IO_A_LO && a[9:0] <= VIDEO_IO_A_HI) ||
                 (a[9:0] >= VIDEO_IO_B_LO && a[9:0] <= VIDEO_IO_B_HI);
        // Narrow decode lets every 1 KB alias in the first 64 KB through
        video_io_hit = low_ok && a[31:16] == 16'h0000 && (!wide || a[15:10] == 6'h00);
    endfunction : video_io_hit

    logic video_hit;
    logic isa_alias;

    always_comb begin
        video_hit = 1'b0;
        if (ctl.video_en) begin
            if (acc.is_io) begin
                video_hit = io_space_en && video_io_hit(acc.addr, ctl.video_wide);
            end else begin
                video_hit = mem_space_en && acc.addr >= VIDEO_MEM_LO &&
                            acc.addr <= VIDEO_MEM_HI;
            end
        end
        isa_alias = ctl.alias_block && acc.is_io && acc.in_window &&
                    acc.addr[31:16] == 16'h0000 && acc.addr[9:8] != ISA_LOW_QUARTER;
        route.fwd_down = 1'b0;
        route.fwd_up = 1'b0;
        if (acc.valid) begin
            if (!acc.upstream) begin
                // Video hit overrides both the window and the alias block
                route.fwd_down = video_hit || (acc.in_window && !isa_alias);
            end else begin
                route.fwd_up = !video_hit && (!acc.in_window || isa_alias);
            end
        end
    end

endmodule : address_router

// file: core/bridge_control_register_logic.sv
// Bridge control and interrupt register with discard, reset, abort and error handling
// Functional notes
// - Discard expiry sends an error message upstream when the message enable is set.
// - Timer length select: 0 counts 2^15 clocks, 1 counts 2^10.
// - Timer starts at queue head; no retry by expiry deletes the transaction.
// - Secondary bus reset output follows the reset bit until software clears it.
// - Forced reset clears secondary side and buffers, not configuration registers.
// - Mode 0: unsupported reads return all ones, I/O writes complete, posted dropped.
// - Mode 1: unsupported completions become target-abort on the secondary bus.
// - Mode 1: aborted posted write sends error message if system-error enabled.
// - Video wide select: 16 address bits compared when 1, 10 bits when 0.
// - Video memory range forwarded downstream and blocked upstream when enabled.
// - Video I/O ranges 3B0-3BB, 3C0-3DF in first 64 KB forwarded downstream.
// - Video forwarding ignores alias block and windows, obeys space enables.
// - Alias block stops top 768 bytes per 1 KB downstream, sends upstream.
// - Secondary system error forwards an error message when forwarding enabled.
// - Parity response enable gates reporting of secondary parity errors; data poisoning is not gated.
// - Parity always generated; bad secondary data forwarded upstream poisoned.
// - Interrupt pin reads 0x00, interrupt line reads 0xff, both read-only.
`timescale 1ns/1ps
module bridge_control_register_logic
    import brctl_pkg::*;
#(
    parameter int LONG_LOG2 = DISCARD_LONG_LOG2,
    parameter int SHORT_LOG2 = DISCARD_SHORT_LOG2
) (
    input wire logic clock,               // Bridge clock, 40 MHz
    input wire logic sys_rst,             // Synchronous reset, high
    // Configuration access
    input wire logic cfg_wr,              // Config write strobe
    input wire logic cfg_rd,              // Config read strobe
    input wire logic [7:0] cfg_addr,      // Config byte offset
    input wire logic [3:0] cfg_be,        // Byte enables
    input wire logic [31:0] cfg_wdata,    // Write data
    output logic [31:0] cfg_rdata,        // Read data, registered
    output logic cfg_rvalid,              // Read data valid pulse
    // Command register bits held elsewhere
    input wire logic io_space_en,         // I/O space enable
    input wire logic mem_space_en,        // Memory space enable
    input wire logic system_error_forward_en,             // Command system-error enable
    input wire logic fatal_sel,           // Severity: 1 fatal, 0 nonfatal
    // Delayed transaction
    input wire logic dly_head_ready,      // Completion at queue head
    input wire logic dly_retried,         // Originating master retried
    output logic dly_discard,             // Delete delayed transaction pulse
    // Secondary bus
    output logic sec_reset_out,           // Secondary bus reset, high
    output logic sec_side_clear,          // Clear secondary side and buffers
    input wire logic secondary_system_error_in, // System error seen, high
    input wire logic sec_parity_err,      // Uncorrectable addr/attr/data error
    input wire logic sec_data_err,        // Uncorrectable data error on read data
    output logic parity_err_report,       // Report parity error pulse
    output logic poison_upstream,         // Mark forwarded data poisoned
    output logic parity_gen_en,           // Parity generation enable
    // Completions and aborts
    input wire logic ur_cpl,              // Unsupported-request completion
    input wire logic ur_is_read,          // The completion is for a read
    input wire logic posted_ma,           // Posted write master-aborted
    output logic ur_target_abort,         // Signal target-abort on secondary
    output logic ur_fill_ones,            // Return all ones / complete normally
    output logic [31:0] ur_read_data,     // Data returned for aborted reads
    output logic posted_drop,             // Posted data discarded
    // Address decode
    input access_t acc,                   // Access under decode
    output route_t route,                 // Routing decision
    // Upstream error messages
    output logic err_msg_valid,           // Error message pulse
    output logic err_msg_fatal            // 1 fatal, 0 nonfatal
);

    initial begin
        if (SHORT_LOG2 < 1 || SHORT_LOG2 > LONG_LOG2 || LONG_LOG2 > 30) begin
            $error("bridge_control_register_logic: bad timer parameters");
        end
    end

    ctl_t ctl_r, ctl_nxt;
    logic discard_stat_r, discard_stat_nxt;
    logic discard_pulse;
    logic wr_hit;
    logic [31:0] rd_word;

    logic err_valid_nxt, err_fatal_nxt;
    logic ta_nxt, ones_nxt, drop_nxt;
    logic perr_nxt, poison_nxt;
    logic rvalid_nxt;
    logic [31:0] rdata_nxt;

    assign wr_hit = cfg_wr && cfg_addr == BRCTL_OFFSET;

    // Control bits; secondary reset never touches them
    always_comb begin
        ctl_nxt = ctl_r;
        if (wr_hit && cfg_be[3]) begin
            ctl_nxt.errmsg_en = cfg_wdata[ERRMSG_EN_BIT];
            ctl_nxt.sec_len_sel = cfg_wdata[SEC_LEN_SEL_BIT];
        end
        if (wr_hit && cfg_be[2]) begin
            ctl_nxt.sec_reset = cfg_wdata[SEC_RESET_BIT];
            ctl_nxt.ma_mode = cfg_wdata[MA_MODE_BIT];
            ctl_nxt.video_wide = cfg_wdata[VIDEO_WIDE_BIT];
            ctl_nxt.video_en = cfg_wdata[VIDEO_EN_BIT];
            ctl_nxt.alias_block = cfg_wdata[ALIAS_BLOCK_BIT];
            ctl_nxt.serr_fwd = cfg_wdata[SERR_FWD_BIT];
            ctl_nxt.parity_resp = cfg_wdata[PARITY_RESP_BIT];
        end
    end

    // Set wins over a same-cycle write-one clear
    always_comb begin
        discard_stat_nxt = discard_stat_r;
        if (wr_hit && cfg_be[3] && cfg_wdata[DISCARD_STAT_BIT]) begin
            discard_stat_nxt = 1'b0;
        end
        if (discard_pulse) begin
            discard_stat_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctl_r <= '0;
            discard_stat_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            discard_stat_r <= discard_stat_nxt;
        end
    end

    assign sec_reset_out = ctl_r.sec_reset;
    assign sec_side_clear = ctl_r.sec_reset;

    discard_timer #(
        .LONG_LOG2(LONG_LOG2),
        .SHORT_LOG2(SHORT_LOG2)
    ) u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .clear(ctl_r.sec_reset),
        .short_sel(ctl_r.sec_len_sel),
        .head_ready(dly_head_ready),
        .retried(dly_retried),
        .expired(discard_pulse)
    );

    assign dly_discard = discard_pulse;

    address_router u_router (
        .ctl(ctl_r),
        .io_space_en(io_space_en),
        .mem_space_en(mem_space_en),
        .acc(acc),
        .route(route)
    );

    // Read image; fixed fields and reserved bits are constants, so writes vanish
    always_comb begin
        rd_word = BRCTL_RESET;
        rd_word[15:8] = INT_PIN_VALUE;
        rd_word[7:0] = INT_LINE_VALUE;
        rd_word[ERRMSG_EN_BIT] = ctl_r.errmsg_en;
        rd_word[DISCARD_STAT_BIT] = discard_stat_r;
        rd_word[SEC_LEN_SEL_BIT] = ctl_r.sec_len_sel;
        rd_word[PRI_LEN_SEL_BIT] = 1'b0;
        rd_word[FAST_B2B_BIT] = 1'b0;
        rd_word[SEC_RESET_BIT] = ctl_r.sec_reset;
        rd_word[MA_MODE_BIT] = ctl_r.ma_mode;
        rd_word[VIDEO_WIDE_BIT] = ctl_r.video_wide;
        rd_word[VIDEO_EN_BIT] = ctl_r.video_en;
        rd_word[ALIAS_BLOCK_BIT] = ctl_r.alias_block;
        rd_word[SERR_FWD_BIT] = ctl_r.serr_fwd;
        rd_word[PARITY_RESP_BIT] = ctl_r.parity_resp;
    end

    // Error events and abort handling; all outputs registered one cycle after cause
    always_comb begin
        rvalid_nxt = cfg_rd;
        rdata_nxt = (cfg_rd && cfg_addr == BRCTL_OFFSET) ? rd_word : 32'h0000_0000;
        err_valid_nxt = 1'b0;
        err_fatal_nxt = fatal_sel;
        ta_nxt = 1'b0;
        ones_nxt = 1'b0;
        drop_nxt = 1'b0;
        if (discard_pulse && ctl_r.errmsg_en) begin
            err_valid_nxt = 1'b1;
        end
        if (secondary_system_error_in && ctl_r.serr_fwd) begin
            err_valid_nxt = 1'b1;
        end
        if (ur_cpl) begin
            if (ctl_r.ma_mode) begin
                ta_nxt = 1'b1;
            end else begin
                ones_nxt = 1'b1;
            end
        end
        if (posted_ma) begin
            drop_nxt = 1'b1;
            if (ctl_r.ma_mode && system_error_forward_en) begin
                err_valid_nxt = 1'b1;
            end
        end
        perr_nxt = sec_parity_err && ctl_r.parity_resp;
        poison_nxt = sec_data_err;
        if (ctl_r.sec_reset) begin
            ta_nxt = 1'b0;
            ones_nxt = 1'b0;
            perr_nxt = 1'b0;
            poison_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_rdata <= '0;
            cfg_rvalid <= 1'b0;
            err_msg_valid <= 1'b0;
            err_msg_fatal <= 1'b0;
            ur_target_abort <= 1'b0;
            ur_fill_ones <= 1'b0;
            posted_drop <= 1'b0;
            parity_err_report <= 1'b0;
            poison_upstream <= 1'b0;
        end else begin
            cfg_rdata <= rdata_nxt;
            cfg_rvalid <= rvalid_nxt;
            err_msg_valid <= err_valid_nxt;
            err_msg_fatal <= err_fatal_nxt;
            ur_target_abort <= ta_nxt;
            ur_fill_ones <= ones_nxt;
            posted_drop <= drop_nxt;
            parity_err_report <= perr_nxt;
            poison_upstream <= poison_nxt;
        end
    end

    // Reads get all ones; writes complete with no data
    assign ur_read_data = ur_is_read ? ALL_ONES : 32'h0000_0000;
    assign parity_gen_en = 1'b1;

endmodule : bridge_control_register_logic

// file: tb/brctl_asserts.sv
// Port-level checker for the bridge control register logic
`timescale 1ns/1ps
module brctl_asserts
    import brctl_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic sys_rst, // Reset
    input wire logic cfg_wr, // Write strobe
    input wire logic cfg_rd, // Read strobe
    input wire logic [7:0] cfg_addr, // Offset
    input wire logic [3:0] cfg_be, // Lanes
    input wire logic [31:0] cfg_wdata, // Write data
    input wire logic [31:0] cfg_rdata, // Read data
    input wire logic cfg_rvalid, // Read valid
    input wire logic system_error_forward_en, // Command error enable
    input wire logic dly_discard, // Discard pulse
    input wire logic sec_reset_out, // Bus reset
    input wire logic sec_side_clear, // Side clear
    input wire logic secondary_system_error_in, // System error
    input wire logic sec_parity_err, // Parity error
    input wire logic parity_err_report, // Parity report
    input wire logic parity_gen_en, // Parity generation
    input wire logic ur_cpl, // Unsupported completion
    input wire logic ur_is_read, // Completion for a read
    input wire logic posted_ma, // Posted write aborted
    input wire logic ur_target_abort, // Target-abort
    input wire logic ur_fill_ones, // Normal completion
    input wire logic [31:0] ur_read_data, // Aborted read data
    input wire logic err_msg_valid // Message pulse
);
    // Shadow of the writable lanes; the bus reset must leave it alone
    logic [31:0] sh_r;
    logic [31:0] sh_nxt;
    always_comb begin
        sh_nxt = sh_r;
        if (cfg_wr && cfg_addr == BRCTL_OFFSET && cfg_be[3]) begin
            sh_nxt[31:24] = cfg_wdata[31:24];
        end
        if (cfg_wr && cfg_addr == BRCTL_OFFSET && cfg_be[2]) begin
            sh_nxt[23:16] = cfg_wdata[23:16];
        end
    end
    always_ff @(posedge clock) begin
        sh_r <= sys_rst ? 32'h0000_0000 : sh_nxt;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_other_offset_zero: assert property (cfg_rd && cfg_addr != BRCTL_OFFSET |=>
        cfg_rvalid && cfg_rdata == 32'h0000_0000) else $error("other offset read not zero");
    a_fixed_low_half: assert property (cfg_rd && cfg_addr == BRCTL_OFFSET |=>
        cfg_rvalid && cfg_rdata[15:0] == 16'h00ff) else $error("interrupt fields wrong");
    a_ro_bits_zero: assert property (cfg_rd && cfg_addr == BRCTL_OFFSET |=>
        cfg_rdata[31:28] == 4'h0 && cfg_rdata[24:23] == 2'b00) else $error("read-only bits set");
    a_reset_tracks_bit: assert property (sh_r[SEC_RESET_BIT] == $past(sh_r[SEC_RESET_BIT])
        |-> sec_reset_out == sh_r[SEC_RESET_BIT]) else $error("bus reset differs from bit");
    a_clear_with_reset: assert property (sec_side_clear == sec_reset_out)
        else $error("side clear differs from bus reset");
    a_parity_always: assert property (parity_gen_en) else $error("parity off");
    a_mode0_fill: assert property (ur_cpl && !sh_r[MA_MODE_BIT] && !sec_reset_out |=>
        ur_fill_ones && !ur_target_abort) else $error("mode 0 completion wrong");
    a_mode0_ones: assert property (ur_is_read && !sh_r[MA_MODE_BIT] |->
        ur_read_data == ALL_ONES) else $error("aborted read data not ones");
    a_mode1_abort: assert property (ur_cpl && sh_r[MA_MODE_BIT] && !sec_reset_out |=>
        ur_target_abort && !ur_fill_ones) else $error("mode 1 target-abort missing");
    a_parity_gate: assert property (sec_parity_err && !sec_reset_out |=>
        parity_err_report == $past(sh_r[PARITY_RESP_BIT])) else $error("parity report wrong");
    a_serr_forward: assert property (secondary_system_error_in && sh_r[SERR_FWD_BIT] &&
        !sec_reset_out |=> err_msg_valid) else $error("system error not forwarded");
    a_msg_has_cause: assert property (err_msg_valid |-> $past(dly_discard &&
        sh_r[ERRMSG_EN_BIT] || secondary_system_error_in && sh_r[SERR_FWD_BIT] ||
        posted_ma && sh_r[MA_MODE_BIT] && system_error_forward_en)) else $error("message without cause");
endmodule : brctl_asserts
bind bridge_control_register_logic brctl_asserts i_chk (.clock, .sys_rst, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .system_error_forward_en, .dly_discard,
    .sec_reset_out, .sec_side_clear, .secondary_system_error_in, .sec_parity_err,
    .parity_err_report, .parity_gen_en, .ur_cpl, .ur_is_read, .posted_ma, .ur_target_abort,
    .ur_fill_ones, .ur_read_data, .err_msg_valid);

// file: tb/secondary_bus_agent.sv
// Model of the masters and targets on the secondary bus
`timescale 1ns/1ps
module secondary_bus_agent (
    input wire logic sec_reset_out, // Bus reset from the bridge
    input wire logic go_serr, // Raise a system error
    input wire logic go_perr, // Raise a parity error
    input wire logic go_derr, // Return bad read data
    input wire logic go_retry, // Repeat the delayed request
    output logic serr_out, // System error to the bridge
    output logic perr_out, // Parity error seen
    output logic derr_out, // Bad data beat seen
    output logic retry_out // Master repeated its request
);
    // Devices held in bus reset stay silent, so nothing leaks through it
    assign serr_out = go_serr && !sec_reset_out;
    assign perr_out = go_perr && !sec_reset_out;
    assign derr_out = go_derr && !sec_reset_out;
    assign retry_out = go_retry && !sec_reset_out;
endmodule : secondary_bus_agent

// file: tb/bridge_control_register_logic_bench.sv
// Self-checking bench for the bridge control register logic
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module bridge_control_register_logic_bench;
    import brctl_pkg::*;
    // Short timer lengths keep the run brief: 64 and 8 clocks
    localparam int LG = 6;
    localparam int SH = 3;
    logic clock = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic io_space_en = 1'b1, mem_space_en = 1'b1, system_error_forward_en = 1'b1, fatal_sel = 1'b0;
    logic dly_head_ready = 1'b0, ur_is_read = 1'b1, go_retry = 1'b0;
    logic [4:0] ev = 5'h00;
    access_t acc = '0;
    logic [31:0] cfg_rdata, ur_read_data;
    logic cfg_rvalid, dly_retried, dly_discard, sec_reset_out, sec_side_clear, ur_cpl;
    logic secondary_system_error_in, sec_parity_err, sec_data_err, parity_err_report;
    logic poison_upstream, parity_gen_en, ur_target_abort, ur_fill_ones, posted_drop;
    logic err_msg_valid, err_msg_fatal, posted_ma;
    route_t route;
    int mismatches = 0, samples_checked = 0, n;
    assign ur_cpl = ev[0];
    assign posted_ma = ev[1];
    bridge_control_register_logic #(.LONG_LOG2(LG), .SHORT_LOG2(SH)) i_dut (
        .clock, .sys_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
        .cfg_rvalid, .io_space_en, .mem_space_en, .system_error_forward_en, .fatal_sel, .dly_head_ready,
        .dly_retried, .dly_discard, .sec_reset_out, .sec_side_clear, .secondary_system_error_in,
        .sec_parity_err, .sec_data_err, .parity_err_report, .poison_upstream, .parity_gen_en,
        .ur_cpl, .ur_is_read, .posted_ma, .ur_target_abort, .ur_fill_ones, .ur_read_data,
        .posted_drop, .acc, .route, .err_msg_valid, .err_msg_fatal);
    secondary_bus_agent i_agent (.sec_reset_out, .go_serr(ev[2]), .go_perr(ev[3]),
        .go_derr(ev[4]), .go_retry, .serr_out(secondary_system_error_in),
        .perr_out(sec_parity_err), .derr_out(sec_data_err), .retry_out(dly_retried));
    initial begin
        forever #12.5 clock = ~clock;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic cfg_write(input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        cfg_wr <= 1'b1;
        cfg_addr <= BRCTL_OFFSET;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_wr <= 1'b0;
    endtask : cfg_write
    task automatic cfg_read(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clock);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clock);
        cfg_rd <= 1'b0;
        #1;
        `CHECK("read valid", 1'b1, cfg_rvalid)
        `CHECK("read data", ex, cfg_rdata)
    endtask : cfg_read
    // Event inputs are held for one cycle; the answer is looked at one cycle later
    task automatic fire(input logic [4:0] k);
        @(posedge clock);
        ev <= k;
        @(posedge clock);
        ev <= 5'h00;
        #1;
    endtask : fire
    task automatic run_timer(input int r);
        @(posedge clock);
        dly_head_ready <= 1'b1;
        n = 0;
        while (n < 200 && dly_discard !== 1'b1) begin
            @(posedge clock);
            go_retry <= (n == r);
            #1;
            n++;
        end
        @(posedge clock);
        dly_head_ready <= 1'b0;
        go_retry <= 1'b0;
        #1;
    endtask : run_timer
    task automatic rt(input logic [2:0] vw, input access_t a, input logic ex);
        cfg_write({11'h000, vw, 18'h00000}, 4'h4);
        @(posedge clock);
        acc <= a;
        @(posedge clock);
        #1;
        `CHECK("route down", ex, route.fwd_down)
    endtask : rt
    initial begin
        #(25 * 5000);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        cfg_read(BRCTL_OFFSET, 32'h0000_00ff);
        cfg_read(8'h40, 32'h0000_0000);
        cfg_write(32'hffff_ffff, 4'hf);
        cfg_read(BRCTL_OFFSET, 32'h0a7f_00ff);
        `CHECK("bus reset", 1'b1, sec_reset_out)
        `CHECK("side clear", 1'b1, sec_side_clear)
        fire(5'b01001);
        `CHECK("abort in reset", 1'b0, ur_target_abort)
        // Bus reset is held well past its minimum width before release
        repeat (20) @(posedge clock);
        cfg_write(32'h0000_0000, 4'h3);
        cfg_write(32'h0000_0000, 4'h4);
        cfg_read(BRCTL_OFFSET, 32'h0a00_00ff);
        `CHECK("bus reset off", 1'b0, sec_reset_out)
        for (int m = 0; m < 2; m++) begin
            cfg_write({10'h000, m[0], 3'b000, m[0], m[0], 16'h0000}, 4'hc);
            @(posedge clock);
            fatal_sel <= m[0];
            fire(5'b00001);
            `CHECK("target abort", m[0], ur_target_abort)
            `CHECK("fill ones", !m[0], ur_fill_ones)
            fire(5'b00010);
            `CHECK("posted msg", m[0], err_msg_valid)
            if (m == 0) `CHECK("posted drop", 1'b1, posted_drop)
            fire(5'b00100);
            `CHECK("serr msg", m[0], err_msg_valid)
            `CHECK("severity", m[0], err_msg_fatal)
            fire(5'b01000);
            `CHECK("parity report", m[0], parity_err_report)
            fire(5'b10000);
            `CHECK("poison", 1'b1, poison_upstream)
        end
        // Lane 2 still holds abort mode, error forwarding and parity response from the loop
        cfg_write(32'h0a00_0000, 4'h8);
        run_timer(-1);
        `CHECK("short count", 1'b1, n >= 8 && n <= 11)
        `CHECK("discard msg", 1'b1, err_msg_valid)
        cfg_read(BRCTL_OFFSET, 32'h0e23_00ff);
        cfg_write(32'h0a00_0000, 4'h8);
        cfg_read(BRCTL_OFFSET, 32'h0e23_00ff);
        cfg_write(32'h0400_0000, 4'h8);
        cfg_read(BRCTL_OFFSET, 32'h0023_00ff);
        run_timer(-1);
        `CHECK("long count", 1'b1, n >= 64 && n <= 67)
        `CHECK("no discard msg", 1'b0, err_msg_valid)
        cfg_read(BRCTL_OFFSET, 32'h0423_00ff);
        cfg_write(32'h0200_0000, 4'h8);
        run_timer(4);
        `CHECK("retry restart", 1'b1, n >= 12 && n <= 18)
        rt(3'b010, {4'b1000, 32'h000a_0000}, 1'b1);
        rt(3'b010, {4'b1000, 32'h000b_ffff}, 1'b1);
        rt(3'b010, {4'b1000, 32'h000c_0000}, 1'b0);
        rt(3'b010, {4'b1010, 32'h000a_0000}, 1'b0);
        `CHECK("video up", 1'b0, route.fwd_up)
        rt(3'b011, {4'b1100, 32'h0000_03bb}, 1'b1);
        rt(3'b010, {4'b1100, 32'h0000_03bc}, 1'b0);
        rt(3'b010, {4'b1100, 32'h0001_03c5}, 1'b0);
        rt(3'b010, {4'b1100, 32'h0000_47c5}, 1'b1);
        rt(3'b110, {4'b1100, 32'h0000_47c5}, 1'b0);
        rt(3'b110, {4'b1100, 32'h0000_03df}, 1'b1);
        rt(3'b001, {4'b1101, 32'h0000_0500}, 1'b0);
        rt(3'b001, {4'b1101, 32'h0000_0410}, 1'b1);
        rt(3'b001, {4'b1111, 32'h0000_0500}, 1'b0);
        `CHECK("alias up", 1'b1, route.fwd_up)
        @(posedge clock);
        mem_space_en <= 1'b0;
        rt(3'b010, {4'b1000, 32'h000a_0000}, 1'b0);
        end_of_test();
    end
endmodule : bridge_control_register_logic_bench
